/* File: hw/audio_port_map.vh */
// Constants for the serial audio port block.
// Assumes byte addressing on a 32-bit Avalon-MM register bus.
`ifndef AUDIO_PORT_MAP_VH
`define AUDIO_PORT_MAP_VH

// Register byte offsets.
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_CHSTAT 4'h8

// Control register fields.
`define CTRL_PORT_EN 0
`define CTRL_SRC_SEL 1
`define CTRL_MUTE 2
`define CTRL_TX_MODE 3
`define CTRL_WL_LO 4
`define CTRL_WL_HI 5
`define CTRL_RESET 6'h33

// Status register fields.
`define STAT_CHANGE 0
`define STAT_MODE_ERR 1
`define STAT_LOCKED 2
`define STAT_TX 3
`define STAT_MODE6_N 4
`define STAT_MODE7_N 5

// Word length codes.
`define WL_16 2'h0
`define WL_18 2'h1
`define WL_20 2'h2
`define WL_24 2'h3

// Preamble codes from the demodulator.
`define PRE_B 2'h0
`define PRE_M 2'h1
`define PRE_W 2'h2

// Frame and block figures.
`define CS_BITS 30
`define BLOCK_FRAMES 192
`define UNIT_GAP_MAX 8
`define SCK_HALF_CYCLES 4

`endif

/* File: hw/sync_bits.v */
// Two-stage synchroniser for independent pin levels.
// Assumes slow levels or clocks far below clk_in.
`timescale 1ns/100ps
module sync_bits #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire rst_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  // First stage; only the second stage reads it.
  reg [WIDTH-1:0] meta_reg;

  // Each bit passes two flip-flops before any logic sees it.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule

/* File: hw/audio_port_validity_mute_chstat.v */
// Serial audio port, validity, muting and channel status.
// Assumes subframes on clk_in and asynchronous pins.
`timescale 1ns/100ps
`include "audio_port_map.vh"

// How it works
// - Receive outputs: off, zero, or data/validity.
// - Stand-alone disable floats all four port pins.
// - Host disable floats data and validity only.
// - Mode strobe rising floats word select, bitclock.
// - Re-enabled output resumes at stereo sample start.
// - Transmit word length set, unused bits zero.
// - External port feeds biphase when enabled.
// - Aux data with external timing, selector chooses.
// - Aux data driven on serial data in transmit while the port is disabled, in receive while it is enabled.
// - Unused transmit combination floats all port pins.
// - Invalid pin is input, ignored with aux.
// - Mute zeroes audio and validity, silences aux.
// - Validity copies invalid input, zero with aux.
// - Capture 30 status bits, map sixteen.
// - Mode error until clean consumer block arrives.
// - Only first byte readable, mode bits inverted.
// - Status taken only from left subframes.
// - Change flag when mapped status differs.
// - First byte bit mapping as specified.
// - Second byte carries category bits reversed.
// - User units start with one, gaps delimit messages.
// - Mute request applied on sample boundaries.
module audio_port_validity_mute_chstat #(
  parameter SCK_HALF = `SCK_HALF_CYCLES,
  parameter BLOCK_FRAMES = `BLOCK_FRAMES
) (
  input wire clk_in,
  input wire rst_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  input wire host_mode_in,
  input wire serial_port_out_enable_in,
  input wire serial_source_select_in,
  input wire mute_in,
  input wire mode_strobe_in,
  input wire pll_locked_in,
  input wire biphase_out_enable_in,
  input wire aux_serial_data_in,
  input wire ws_in,
  output reg ws_out,
  output reg ws_oe_n_out,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe_n_out,
  input wire sd_in,
  output reg sd_out,
  output reg sd_oe_n_out,
  input wire invalid_in,
  output reg invalid_out,
  output reg invalid_oe_n_out,
  input wire sf_valid_in,
  input wire [1:0] sf_preamble_in,
  input wire [23:0] sf_audio_in,
  input wire sf_validity_in,
  input wire sf_user_in,
  input wire sf_chstat_in,
  output reg [23:0] tx_audio_out,
  output reg tx_validity_out,
  output reg tx_left_out,
  output reg tx_audio_valid_out,
  output reg status_mode_error_out,
  output reg [7:0] cs_byte0_out,
  output reg [7:0] cs_byte1_out,
  output reg [7:0] user_unit_out,
  output reg user_unit_valid_out,
  output reg user_msg_start_out
);
  // Pins after two flops, from ws at bit 0 up to encoder enable at bit 11.
  wire [11:0] s;
  sync_bits #(.WIDTH(12)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({biphase_out_enable_in, pll_locked_in, host_mode_in, serial_source_select_in,
      serial_port_out_enable_in, mute_in, mode_strobe_in, invalid_in, aux_serial_data_in,
      sd_in, sck_in, ws_in}),
    .sync_out(s)
  );

  reg [5:0] ctrl_reg; // Software control bits.
  reg change_reg; // Sticky channel-status change flag.
  reg ack_reg; // Second cycle of a bus access.
  reg tx_mode_reg; // Latched receive/transmit mode.
  reg strobe_d_reg; // Previous strobe level for edge finding.
  reg mute_eff_reg; // Mute applied at stereo start.
  reg en_eff_reg; // Port enable applied at stereo start.

  // Host mode combines pin and bit; stand-alone uses the pin.
  wire host = s[9];
  wire pe_eff = host ? (s[7] & ctrl_reg[`CTRL_PORT_EN]) : s[7];
  wire sel_sd = host ? (s[8] & ctrl_reg[`CTRL_SRC_SEL]) : s[8];
  wire mute_req = s[6] | (host & ctrl_reg[`CTRL_MUTE]);
  wire [1:0] wl = host ? ctrl_reg[`CTRL_WL_HI:`CTRL_WL_LO] : `WL_24;
  wire tx_active = tx_mode_reg & host;
  wire locked = s[10];

  // Significant bits per word-length code.
  function [4:0] wl_bits;
    input [1:0] code;
    begin
      case (code)
        `WL_16: wl_bits = 5'd16;
        `WL_18: wl_bits = 5'd18;
        `WL_20: wl_bits = 5'd20;
        default: wl_bits = 5'd24;
      endcase
    end
  endfunction
  wire [4:0] wl_n = wl_bits(wl);
  wire [23:0] wl_mask = 24'hffffff << (5'd24 - wl_n);

  // Avalon access takes one wait cycle.
  wire bus_req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~ack_reg;
  wire wr_do = avs_write_in & ack_reg & avs_byteenable_in[0];

  // Receive-side word clock and bit counter.
  reg [7:0] div_reg; // Half-period counter of the bit clock.
  reg sck_gen_reg; // Generated bit clock level.
  reg [5:0] bit_reg; // Bit slot within the stereo frame.
  reg [23:0] left_reg; // Latest received left sample.
  reg [23:0] right_reg; // Latest received right sample.
  reg vl_reg; // Latest left validity bit.
  reg vr_reg; // Latest right validity bit.
  reg [23:0] out_l_reg; // Left sample being shifted out.
  reg [23:0] out_r_reg; // Right sample being shifted out.
  reg out_vl_reg; // Validity of the left sample shifted.
  reg out_vr_reg; // Validity of the right sample shifted.
  reg iec_bit_reg; // Serial bit from decoded audio.
  wire rx_fall = (div_reg == SCK_HALF - 1) && sck_gen_reg;
  wire [5:0] bit_next = bit_reg + 6'd1;
  wire [4:0] slot = bit_next[4:0];
  wire [4:0] bidx = 5'd24 - slot;
  wire [23:0] cur_word = bit_next[5] ? out_r_reg : out_l_reg;

  // Transmit-side capture state.
  reg sck_d_reg; // Previous external bit clock level.
  reg ws_last_reg; // Word select of the current word.
  reg [23:0] acc_reg; // Word being assembled.
  reg [4:0] cnt_reg; // Bits taken into the current word.
  reg inv_cap_reg; // Invalid flag taken with the MSB.
  wire tx_rise = s[1] & ~sck_d_reg;
  wire tx_bit = sel_sd ? s[2] : s[3];
  wire tx_unused = ~pe_eff & sel_sd;
  wire [23:0] acc_next = (cnt_reg < wl_n) ? (acc_reg | ({23'h0, tx_bit} << (5'd23 - cnt_reg))) : acc_reg;
  wire ws_change = tx_rise & (s[0] != ws_last_reg);
  // A stereo sample starts at word select falling.
  wire stereo_start = tx_active ? (ws_change & ~s[0]) : (rx_fall & (bit_reg == 6'd63));

  // Mode latch and sample-boundary mute and enable.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_mode_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
      mute_eff_reg <= 1'b1;
      en_eff_reg <= 1'b0;
    end else begin
      strobe_d_reg <= s[5];
      // The mode changes only on the strobe's rising edge.
      if (s[5] & ~strobe_d_reg) begin
        tx_mode_reg <= host & ctrl_reg[`CTRL_TX_MODE];
      end
      // Mute follows the request at a stereo start.
      if (stereo_start) begin
        mute_eff_reg <= mute_req;
      end
      // Disable acts at once; enable waits for a stereo start.
      if (~pe_eff) begin
        en_eff_reg <= 1'b0;
      end else if (stereo_start) begin
        en_eff_reg <= 1'b1;
      end
    end
  end

  // Receive: serialise decoded samples.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= 8'h00;
      sck_gen_reg <= 1'b0;
      bit_reg <= 6'h3f;
      left_reg <= 24'h000000;
      right_reg <= 24'h000000;
      vl_reg <= 1'b0;
      vr_reg <= 1'b0;
      out_l_reg <= 24'h000000;
      out_r_reg <= 24'h000000;
      out_vl_reg <= 1'b0;
      out_vr_reg <= 1'b0;
      iec_bit_reg <= 1'b0;
    end else begin
      // Left subframes carry block-start or left preambles.
      if (sf_valid_in) begin
        if (sf_preamble_in == `PRE_W) begin
          right_reg <= sf_audio_in & wl_mask;
          vr_reg <= sf_validity_in;
        end else begin
          left_reg <= sf_audio_in & wl_mask;
          vl_reg <= sf_validity_in;
        end
      end
      // The free-running divider keeps the bit clock glitch-free.
      if (div_reg == SCK_HALF - 1) begin
        div_reg <= 8'h00;
        sck_gen_reg <= ~sck_gen_reg;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
      // Pairs are copied in slot 62, which is always zero.
      if (rx_fall) begin
        bit_reg <= bit_next;
        if (bit_reg == 6'd62) begin
          out_l_reg <= left_reg;
          out_r_reg <= right_reg;
          out_vl_reg <= vl_reg;
          out_vr_reg <= vr_reg;
        end
        // One delay slot, then MSB first; zero past 24 bits.
        iec_bit_reg <= (slot >= 5'd1 && slot <= 5'd24) ? cur_word[bidx] : 1'b0;
      end
    end
  end

  // Transmit: assemble words for the encoder.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_d_reg <= 1'b0;
      ws_last_reg <= 1'b0;
      acc_reg <= 24'h000000;
      cnt_reg <= 5'h00;
      inv_cap_reg <= 1'b0;
      tx_audio_out <= 24'h000000;
      tx_validity_out <= 1'b0;
      tx_left_out <= 1'b0;
      tx_audio_valid_out <= 1'b0;
    end else begin
      sck_d_reg <= s[1];
      tx_audio_valid_out <= 1'b0;
      if (tx_active & tx_rise) begin
        if (ws_change) begin
          // The bit at the word select change ends the old word.
          tx_audio_out <= mute_eff_reg ? 24'h000000 : acc_next;
          tx_validity_out <= ~mute_eff_reg & sel_sd & inv_cap_reg;
          tx_left_out <= ~ws_last_reg;
          tx_audio_valid_out <= s[11] & ~tx_unused;
          acc_reg <= 24'h000000;
          cnt_reg <= 5'h00;
          ws_last_reg <= s[0];
        end else begin
          // Bits past the word length stay zero.
          acc_reg <= acc_next;
          if (cnt_reg == 5'h00) begin
            // Invalid counts only with the serial source.
            inv_cap_reg <= sel_sd & s[4];
          end
          if (cnt_reg != 5'h1f) begin
            cnt_reg <= cnt_reg + 5'h01;
          end
        end
      end
    end
  end

  // Pin drivers; enables are active low.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ws_out <= 1'b0;
      ws_oe_n_out <= 1'b1;
      sck_out <= 1'b0;
      sck_oe_n_out <= 1'b1;
      sd_out <= 1'b0;
      sd_oe_n_out <= 1'b1;
      invalid_out <= 1'b0;
      invalid_oe_n_out <= 1'b1;
    end else if (tx_active) begin
      // Timing and invalid pins are inputs here.
      ws_oe_n_out <= 1'b1;
      sck_oe_n_out <= 1'b1;
      invalid_oe_n_out <= 1'b1;
      invalid_out <= 1'b0;
      // Only the aux monitor combination drives serial data.
      sd_oe_n_out <= pe_eff | sel_sd;
      sd_out <= ~mute_eff_reg & s[3];
      ws_out <= 1'b0;
      sck_out <= 1'b0;
    end else begin
      ws_out <= bit_reg[5];
      sck_out <= sck_gen_reg;
      // Host mode keeps timing pins driven while receiving.
      ws_oe_n_out <= ~host & ~pe_eff;
      sck_oe_n_out <= ~host & ~pe_eff;
      sd_oe_n_out <= ~(pe_eff & en_eff_reg);
      invalid_oe_n_out <= ~(pe_eff & en_eff_reg);
      if (~locked | mute_eff_reg) begin
        sd_out <= 1'b0;
        invalid_out <= 1'b0;
      end else if (~sel_sd) begin
        sd_out <= s[3];
        invalid_out <= 1'b0;
      end else begin
        sd_out <= iec_bit_reg;
        invalid_out <= bit_reg[5] ? out_vr_reg : out_vl_reg;
      end
    end
  end

  // Channel-status capture from left subframes only.
  reg [29:0] cs_reg; // Status bits of the current block.
  reg [7:0] fidx_reg; // Left subframe index within the block.
  reg started_reg; // A block start has been seen.
  reg mode6_reg; // Received status bit 6.
  reg mode7_reg; // Received status bit 7.
  wire is_left = sf_valid_in & (sf_preamble_in != `PRE_W);
  wire is_start = sf_preamble_in == `PRE_B;
  wire [7:0] cs_idx = is_start ? 8'h00 : fidx_reg;
  wire [29:0] cs_full = {sf_chstat_in, cs_reg[28:0]};
  wire [7:0] map0 = {cs_full[0], cs_full[1], cs_full[2], cs_full[3], cs_full[24], cs_full[25],
    cs_full[28], cs_full[29]};
  wire [7:0] map1 = {cs_full[8], cs_full[9], cs_full[10], cs_full[11], cs_full[12], cs_full[13],
    cs_full[14], cs_full[15]};
  wire cs_done = is_left & (is_start | started_reg) & (cs_idx == `CS_BITS - 1);
  wire cs_changed = cs_done & ({map1, map0} != {cs_byte1_out, cs_byte0_out});

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_reg <= 30'h00000000;
      fidx_reg <= 8'h00;
      started_reg <= 1'b0;
      mode6_reg <= 1'b0;
      mode7_reg <= 1'b0;
      cs_byte0_out <= 8'h00;
      cs_byte1_out <= 8'h00;
      status_mode_error_out <= 1'b0;
    end else if (is_left & (is_start | started_reg)) begin
      started_reg <= 1'b1;
      fidx_reg <= cs_idx + 8'h01;
      if (cs_idx < `CS_BITS) begin
        cs_reg[cs_idx[4:0]] <= sf_chstat_in;
      end
      // Professional mode sets the error at once.
      if (cs_idx == 8'h00 && sf_chstat_in) begin
        status_mode_error_out <= 1'b1;
      end
      if (cs_done) begin
        cs_byte0_out <= map0;
        cs_byte1_out <= map1;
        mode6_reg <= cs_full[6];
        mode7_reg <= cs_full[7];
      end
      // Cleared after a whole consumer block.
      if (cs_idx == BLOCK_FRAMES - 1 && ~cs_reg[0]) begin
        status_mode_error_out <= 1'b0;
      end
    end
  end

  // User units open with a one; long zero runs open a message.
  reg in_unit_reg; // Inside an information unit.
  reg [2:0] ucnt_reg; // Bits taken of the current unit.
  reg [6:0] ush_reg; // Unit bits so far.
  reg [3:0] zero_reg; // Zero bits since the last unit, saturating.
  reg msg_pend_reg; // The current unit opens a message.

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_unit_reg <= 1'b0;
      ucnt_reg <= 3'h0;
      ush_reg <= 7'h00;
      zero_reg <= 4'h9;
      msg_pend_reg <= 1'b0;
      user_unit_out <= 8'h00;
      user_unit_valid_out <= 1'b0;
      user_msg_start_out <= 1'b0;
    end else begin
      user_unit_valid_out <= 1'b0;
      if (sf_valid_in & ~tx_active) begin
        if (~in_unit_reg) begin
          if (sf_user_in) begin
            // More than eight zeros before this start bit mark a new message.
            in_unit_reg <= 1'b1;
            ucnt_reg <= 3'h1;
            ush_reg <= 7'h01;
            msg_pend_reg <= zero_reg > `UNIT_GAP_MAX;
            zero_reg <= 4'h0;
          end else if (zero_reg != 4'hf) begin
            zero_reg <= zero_reg + 4'h1;
          end
        end else begin
          ush_reg <= {ush_reg[5:0], sf_user_in};
          ucnt_reg <= ucnt_reg + 3'h1;
          if (ucnt_reg == 3'h7) begin
            in_unit_reg <= 1'b0;
            user_unit_out <= {ush_reg, sf_user_in};
            user_unit_valid_out <= 1'b1;
            user_msg_start_out <= msg_pend_reg;
          end
        end
      end
    end
  end

  // Register writes; a hardware set beats a clear.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= `CTRL_RESET;
      change_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (wr_do && avs_address_in == `OFS_CTRL) begin
        ctrl_reg <= avs_writedata_in[5:0];
      end
      if (cs_changed) begin
        change_reg <= 1'b1;
      end else if (wr_do && avs_address_in == `OFS_STATUS && avs_writedata_in[`STAT_CHANGE]) begin
        change_reg <= 1'b0;
      end
    end
  end

  // Read data loads in the wait cycle and stands after it.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in & ~ack_reg) begin
      case (avs_address_in)
        `OFS_CTRL: avs_readdata_out <= {26'h0, ctrl_reg};
        `OFS_STATUS: avs_readdata_out <= {26'h0, ~mode7_reg, ~mode6_reg, tx_active, locked,
          status_mode_error_out, change_reg};
        `OFS_CHSTAT: avs_readdata_out <= {24'h0, cs_byte0_out};
        default: avs_readdata_out <= 32'h00000000;
      endcase
    end
  end
endmodule

/* File: sim/audio_port_sva.sv */
// Checker bound into the audio port block.
// Assumes pins hold long enough to pass the synchronisers.
`timescale 1ns/100ps
`include "audio_port_map.vh"
module audio_port_sva (
  input wire clk_in,
  input wire rst_in,
  input wire host_mode_in,
  input wire serial_port_out_enable_in,
  input wire mute_in,
  input wire pll_locked_in,
  input wire ws_out,
  input wire ws_oe_n_out,
  input wire sck_oe_n_out,
  input wire sd_out,
  input wire sd_oe_n_out,
  input wire invalid_out,
  input wire invalid_oe_n_out,
  input wire sf_valid_in,
  input wire [1:0] sf_preamble_in,
  input wire sf_chstat_in,
  input wire [23:0] tx_audio_out,
  input wire tx_validity_out,
  input wire tx_audio_valid_out,
  input wire status_mode_error_out,
  input wire [7:0] cs_byte0_out,
  input wire [7:0] user_unit_out,
  input wire user_unit_valid_out
);
  // Saturating run lengths; 1100 cycles outlast a stereo sample.
  reg [10:0] mute_run;
  reg [10:0] unlk_run;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // A run restarts when mute_in drops or pll_locked_in rises.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mute_run <= 11'h0;
      unlk_run <= 11'h0;
    end else begin
      mute_run <= mute_in ? mute_run + {10'h0, ~&mute_run} : 11'h0;
      unlk_run <= !pll_locked_in ? unlk_run + {10'h0, ~&unlk_run} : 11'h0;
    end
  end
  chk_alone_float: assert property ((!host_mode_in && !serial_port_out_enable_in)[*5] |->
    ws_oe_n_out && sck_oe_n_out && sd_oe_n_out && invalid_oe_n_out) else $error("port not floated");
  chk_host_float: assert property ((host_mode_in && !serial_port_out_enable_in)[*5] ##0 !ws_oe_n_out |->
    sd_oe_n_out && invalid_oe_n_out) else $error("data pins still driven");
  chk_unlock_zero: assert property (unlk_run > 11'h44c && !sd_oe_n_out |-> !sd_out && !invalid_out)
    else $error("unlocked output not zero");
  chk_mute_zero: assert property (mute_run > 11'h44c && !sd_oe_n_out |->
    !sd_out && (invalid_oe_n_out || !invalid_out)) else $error("muted output not zero");
  chk_tx_mute: assert property (mute_run > 11'h44c && tx_audio_valid_out |->
    tx_audio_out == 24'h0 && !tx_validity_out) else $error("muted word not zero");
  chk_resume_start: assert property ($fell(sd_oe_n_out) && !ws_oe_n_out |-> !ws_out)
    else $error("output resumed mid sample");
  chk_err_set: assert property ($rose(status_mode_error_out) |->
    $past(sf_valid_in && sf_preamble_in == `PRE_B && sf_chstat_in)) else $error("mode error without cause");
  chk_cs_left: assert property ($changed(cs_byte0_out) |->
    $past(sf_valid_in && sf_preamble_in != `PRE_W)) else $error("status taken off a right subframe");
  chk_unit_msb: assert property (user_unit_valid_out |-> user_unit_out[7])
    else $error("unit lacks start bit");
endmodule

/* File: sim/i2s_source_model.sv */
// Serial audio source with a 400 ns bit clock.
// Assumes the device listens while run_in is high.
`timescale 1ns/100ps
module i2s_source_model (
  input wire run_in,
  input wire [23:0] word_in,
  input wire inv_in,
  output reg ws_out,
  output reg sck_out,
  output reg sd_out,
  output reg aux_out,
  output reg inv_out
);
  integer b;
  reg [4:0] k;
  // 64 slots a pass; the clock stands still while run_in is low.
  initial begin
    ws_out = 1'h1;
    sck_out = 1'h0;
    sd_out = 1'h0;
    aux_out = 1'h1;
    inv_out = 1'h0;
    #7;
    forever begin
      wait (run_in);
      for (b = 0; b < 64; b = b + 1) begin
        k = b[4:0];
        ws_out = b[5];
        sd_out = (k >= 5'h1 && k <= 5'h18) ? word_in[5'h18 - k] : 1'h0;
        // Aux carries the inverse word to tell sources apart.
        aux_out = sd_out ^ (k >= 5'h1 && k <= 5'h18);
        inv_out = inv_in;
        #200 sck_out = 1'h1;
        #200 sck_out = 1'h0;
      end
      // Idle data, aux and invalid lines show the inverse level.
      sd_out = ~sd_out;
      aux_out = ~aux_out;
      inv_out = ~inv_out;
    end
  end
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the serial audio port block.
// Assumes 32-frame blocks.
`timescale 1ns/100ps
`include "audio_port_map.vh"
module tb;
  reg clk_in, rst_in, avs_read_in, avs_write_in, host_mode_in, serial_port_out_enable_in;
  reg serial_source_select_in, mute_in, mode_strobe_in, pll_locked_in, biphase_out_enable_in;
  reg sf_valid_in, sf_validity_in, sf_user_in, sf_chstat_in, m_run, m_inv;
  reg [3:0] avs_address_in, avs_byteenable_in;
  reg [31:0] avs_writedata_in, rd;
  reg [1:0] sf_preamble_in;
  reg [23:0] sf_audio_in, m_word;
  reg [29:0] cs_pat;
  wire [31:0] avs_readdata_out;
  wire [23:0] tx_audio_out;
  wire [7:0] cs_byte0_out, cs_byte1_out, user_unit_out;
  wire avs_waitrequest_out, ws_out, ws_oe_n_out, sck_out, sck_oe_n_out, sd_out, sd_oe_n_out;
  wire invalid_out, invalid_oe_n_out, tx_validity_out, tx_left_out, tx_audio_valid_out;
  wire status_mode_error_out, user_unit_valid_out, user_msg_start_out, aux_serial_data_in;
  wire ws_in, sck_in, sd_in, invalid_in, m_ws, m_sck, m_sd, m_inv_pin;
  wire [3:0] oes = {sd_oe_n_out, invalid_oe_n_out, ws_oe_n_out, sck_oe_n_out};
  integer bad_count, n_tests, cyc, i;
  localparam [29:0] CS_A = 30'h0a5c3c90;
  localparam [29:0] CS_B = 30'h1234abcd;
  // A low enable gives the device the wire.
  assign ws_in = ws_oe_n_out ? m_ws : ws_out;
  assign sck_in = sck_oe_n_out ? m_sck : sck_out;
  assign sd_in = sd_oe_n_out ? m_sd : sd_out;
  assign invalid_in = invalid_oe_n_out ? m_inv_pin : invalid_out;
  audio_port_validity_mute_chstat #(.BLOCK_FRAMES(32)) i_audio_port_validity_mute_chstat (.*);
  i2s_source_model i_i2s_source_model (.run_in(m_run), .word_in(m_word), .inv_in(m_inv), .ws_out(m_ws),
    .sck_out(m_sck), .sd_out(m_sd), .aux_out(aux_serial_data_in), .inv_out(m_inv_pin));
  // Expected byte maps from the status pattern.
  function [7:0] map0(input [29:0] c);
    map0 = {c[0], c[1], c[2], c[3], c[24], c[25], c[28], c[29]};
  endfunction
  function [7:0] map1(input [29:0] c);
    map1 = {c[8], c[9], c[10], c[11], c[12], c[13], c[14], c[15]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Requests stand until waitrequest is seen low.
  task bus_wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= 1'h1;
      @(negedge clk_in);
      while (avs_waitrequest_out !== 1'h0) @(negedge clk_in);
      @(posedge clk_in);
      avs_write_in <= 1'h0;
    end
  endtask
  task bus_rd(input [3:0] a, output [31:0] d);
    begin
      @(posedge clk_in);
      avs_address_in <= a;
      avs_read_in <= 1'h1;
      @(negedge clk_in);
      while (avs_waitrequest_out !== 1'h0) @(negedge clk_in);
      @(posedge clk_in);
      d = avs_readdata_out;
      avs_read_in <= 1'h0;
    end
  endtask
  // The fifth word is judged; early ones may be partial.
  task tx_check(input [23:0] ea, input ev);
    begin
      repeat (5) @(posedge tx_audio_valid_out);
      #1;
      chk(tx_audio_out, ea);
      chk(tx_validity_out, ev);
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    clk_in = 1'h0;
    forever #25 clk_in = ~clk_in;
  end
  // A hang ends the run as a failure.
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  // Left subframes carry the pattern, right ones a poison 1.
  initial begin : feeder
    integer f, u;
    reg [29:0] cs;
    u = 0;
    wait (rst_in === 1'h0);
    forever begin
      cs = cs_pat;
      for (f = 0; f < 64; f = f + 1) begin
        repeat (3) @(posedge clk_in);
        sf_valid_in <= 1'h1;
        sf_preamble_in <= f[0] ? `PRE_W : (f == 0 ? `PRE_B : `PRE_M);
        sf_chstat_in <= f[0] ? 1'h1 : (f < 60 ? cs[f >> 1] : 1'h0);
        sf_user_in <= (u < 8) ? 8'hc5 >> (7 - u) & 8'h1 : 1'h0;
        u = (u + 1) % 20;
        @(posedge clk_in);
        sf_valid_in <= 1'h0;
      end
    end
  end
  initial begin
    rst_in = 1'h1; avs_address_in = 4'h0; avs_read_in = 1'h0; avs_write_in = 1'h0;
    avs_writedata_in = 32'h0; avs_byteenable_in = 4'hf; host_mode_in = 1'h1; mute_in = 1'h0;
    serial_port_out_enable_in = 1'h1; serial_source_select_in = 1'h1; mode_strobe_in = 1'h0;
    pll_locked_in = 1'h1; biphase_out_enable_in = 1'h1; sf_valid_in = 1'h0; sf_preamble_in = 2'h0;
    sf_audio_in = 24'h0; sf_validity_in = 1'h1; sf_user_in = 1'h0; sf_chstat_in = 1'h0;
    m_run = 1'h0; m_word = 24'hc3a5e1; m_inv = 1'h1; cs_pat = CS_A; bad_count = 0; n_tests = 0; cyc = 0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'h0;
    bus_rd(`OFS_CTRL, rd);
    chk(rd, 32'h33);
    bus_rd(4'hc, rd);
    chk(rd, 32'h0);
    repeat (2000) @(posedge clk_in);
    chk({invalid_oe_n_out, invalid_out}, 2'h1);
    bus_rd(`OFS_STATUS, rd);
    chk({rd[5:4], rd[1:0]}, {~CS_A[7], ~CS_A[6], 2'h1});
    bus_rd(`OFS_CHSTAT, rd);
    chk(rd, map0(CS_A));
    chk(cs_byte1_out, map1(CS_A));
    @(posedge user_unit_valid_out);
    #1;
    chk({user_msg_start_out, user_unit_out}, 9'h1c5);
    bus_wr(`OFS_STATUS, 32'h1);
    repeat (800) @(posedge clk_in);
    bus_rd(`OFS_STATUS, rd);
    chk(rd[0], 1'h0);
    cs_pat = CS_B;
    repeat (800) @(posedge clk_in);
    bus_rd(`OFS_STATUS, rd);
    chk(rd[1:0], 2'h3);
    bus_rd(`OFS_CHSTAT, rd);
    chk(rd, map0(CS_B));
    cs_pat = CS_A;
    repeat (800) @(posedge clk_in);
    chk(status_mode_error_out, 1'h0);
    mute_in <= 1'h1;
    repeat (1200) @(posedge clk_in);
    chk({sd_out, invalid_out}, 2'h0);
    mute_in <= 1'h0;
    pll_locked_in <= 1'h0;
    repeat (1200) @(posedge clk_in);
    chk({sd_out, invalid_out}, 2'h0);
    pll_locked_in <= 1'h1;
    serial_port_out_enable_in <= 1'h0;
    repeat (10) @(posedge clk_in);
    chk(oes, 4'hc);
    host_mode_in <= 1'h0;
    repeat (10) @(posedge clk_in);
    chk(oes, 4'hf);
    host_mode_in <= 1'h1;
    serial_port_out_enable_in <= 1'h1;
    repeat (1200) @(posedge clk_in);
    chk(oes, 4'h0);
    bus_wr(`OFS_CTRL, 32'h3b);
    mode_strobe_in <= 1'h1;
    repeat (4) @(posedge clk_in);
    mode_strobe_in <= 1'h0;
    repeat (10) @(posedge clk_in);
    chk(oes[1:0], 2'h3);
    m_run = 1'h1;
    for (i = 0; i < 4; i = i + 1) begin
      bus_wr(`OFS_CTRL, 32'h0b | (i << 4));
      tx_check(m_word & (24'hffffff << (i == 3 ? 0 : 8 - 2 * i)), 1'h1);
    end
    serial_source_select_in <= 1'h0;
    tx_check(~m_word, 1'h0);
    serial_port_out_enable_in <= 1'h0;
    tx_check(~m_word, 1'h0);
    chk(sd_oe_n_out, 1'h0);
    serial_port_out_enable_in <= 1'h1;
    serial_source_select_in <= 1'h1;
    mute_in <= 1'h1;
    tx_check(24'h0, 1'h0);
    mute_in <= 1'h0;
    serial_port_out_enable_in <= 1'h0;
    repeat (1500) @(posedge clk_in);
    chk({oes[1:0], oes[3]}, 3'h7);
    m_run = 1'h0;
    final_report;
  end
endmodule
bind audio_port_validity_mute_chstat audio_port_sva i_audio_port_sva (.*);
